//--- verilog/gap_write_decoder.sv
// gap write decoder: counts field clocks between gaps, decodes frames
// assumes field_clk and field_gap come from the analog front end,
// asynchronous to sys_clk, which must run well above the field clock
`timescale 1ns/10ps
`include "gap_write_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// RULE_01: write frame opens with opcode 10 then one lock bit.
// RULE_02: after lock bit come 32 payload bits for the block.
// RULE_03: last three frame bits select the destination block.
// RULE_04: program only when exactly the expected bit count arrived.
// RULE_05: each gap restarts a field clock counter read at next gap.
// RULE_06: count 16 to 32 inclusive decodes as zero.
// RULE_07: count 48 to 64 decodes as one.
// RULE_08: other counts are errors; leave write mode, back to read. Counts above 64 end the frame here instead.
// RULE_09: count field pulses until gap detection, decay pulses included.
// RULE_10: reader times field-on and gap intervals within recommended windows.
// RULE_11: high Q antenna: reader lengthens gaps, shortens on-times.
// RULE_12: with request mode bit set in block 0, stay asleep.
// RULE_13: wake-up command is wake opcode plus 32-bit password.
// RULE_14: matching wake-up gives internal reset then read mode.
// RULE_15: stop opcode makes the device cease modulating.
// RULE_16: delivered config: Manchester, RF/32, readout up to block 2.
// RULE_17: read mode answers by damping; writes only via field gaps.
// RULE_18: wrong wake-up password leaves device asleep, silent.
module gap_write_decoder
(
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	input  wire logic                    clk_en,
	input  wire logic                    field_clk,
	input  wire logic                    field_gap,
	input  wire logic [3:0]              addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [31:0]             rdata,
	output logic                         irq,
	output logic                         modulate_en,
	output logic                         write_mode,
	output gap_write_pkg::prog_req_t     prog
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [1:0] clk_sync;
	logic [1:0] gap_sync;
	logic       clk_last;
	logic       gap_last;
	logic       clk_rise;
	logic       gap_rise;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			clk_sync <= 2'h0;
			gap_sync <= 2'h0;
			clk_last <= 1'b0;
			gap_last <= 1'b0;
		end
		else if (clk_en)
		begin
			clk_sync <= {clk_sync[0], field_clk};
			gap_sync <= {gap_sync[0], field_gap};
			clk_last <= clk_sync[1];
			gap_last <= gap_sync[1];
		end
	end

	assign clk_rise = clk_sync[1] & ~clk_last;
	assign gap_rise = gap_sync[1] & ~gap_last;

	////////////////////////////////////////////////////////////////////////
	// field clock counter between gaps
	logic [6:0] field_cnt;
	logic       gap_open;

	// pulses keep counting until the gap is actually detected, so the
	// decaying field adds to the count [RULE_09]
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			field_cnt <= 7'h0;
		else if (clk_en)
		begin
			if (gap_rise)
				field_cnt <= 7'h0; // [RULE_05]
			else if (clk_rise && !gap_sync[1] && field_cnt != `CNT_SAT)
				field_cnt <= field_cnt + 7'h1; // [RULE_05]
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			gap_open <= 1'b0;
		else if (clk_en && gap_rise)
			gap_open <= 1'b1;
	end

	function automatic logic [1:0] classify(input logic [6:0] c);
		// bit 1 flags a valid bit, bit 0 is its value
		if (c >= `ZERO_MIN && c <= `ZERO_MAX)
			classify = 2'h2; // [RULE_06]
		else if (c >= `ONE_MIN && c <= `ONE_MAX)
			classify = 2'h3; // [RULE_07]
		else
			classify = 2'h0; // [RULE_08]
	endfunction : classify

	logic [1:0] bit_class;
	assign bit_class = classify(field_cnt);

	////////////////////////////////////////////////////////////////////////
	// frame receiver
	gap_write_pkg::rx_state_t rx_state;
	logic [37:0] shift;
	logic [5:0]  nbits;
	logic        frame_end;
	logic        bit_err;

	// a gap that ends an interval longer than any valid bit closes frame
	assign frame_end = gap_rise && gap_open && field_cnt > `ONE_MAX
		&& rx_state == gap_write_pkg::RX_BITS;
	assign bit_err = gap_rise && gap_open && !bit_class[1]
		&& rx_state == gap_write_pkg::RX_BITS && !frame_end;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rx_state <= gap_write_pkg::RX_IDLE;
			shift    <= 38'h0;
			nbits    <= 6'h0;
		end
		else if (clk_en)
		begin
			case (rx_state)
				gap_write_pkg::RX_IDLE:
				begin
					// start gap opens write mode
					if (gap_rise)
					begin
						rx_state <= gap_write_pkg::RX_BITS;
						nbits    <= 6'h0;
					end
				end
				gap_write_pkg::RX_BITS:
				begin
					if (frame_end)
						rx_state <= gap_write_pkg::RX_DONE;
					else if (bit_err)
						rx_state <= gap_write_pkg::RX_IDLE; // [RULE_08]
					else if (gap_rise && nbits != `FRAME_BITS)
					begin
						shift <= {shift[36:0], bit_class[0]};
						nbits <= nbits + 6'h1;
					end
					else if (gap_rise)
						nbits <= nbits + 6'h1;
				end
				gap_write_pkg::RX_DONE:
					rx_state <= gap_write_pkg::RX_IDLE;
				default:
					rx_state <= gap_write_pkg::RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame interpretation
	logic [31:0] cfg;
	logic [31:0] pwd;
	logic        awake;
	logic        stopped;
	logic        is_write;
	logic        is_wake;
	logic        is_stop;
	logic        wake_ok;
	logic        done;

	assign done     = clk_en && rx_state == gap_write_pkg::RX_DONE;
	// opcode, lock, 32 data, 3 address bits in exact count [RULE_01]
	assign is_write = done && nbits == `FRAME_BITS
		&& shift[37:36] == `OP_WRITE; // [RULE_04]
	assign is_wake  = done && nbits == `WAKE_BITS
		&& shift[33:32] == `OP_WAKE; // [RULE_13]
	assign wake_ok  = is_wake && shift[31:0] == pwd; // [RULE_18]
	assign is_stop  = done && nbits == `STOP_BITS
		&& shift[1:0] == `OP_STOP; // [RULE_15]

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			prog <= '0;
		else if (clk_en)
		begin
			prog.req <= is_write; // [RULE_04]
			if (is_write)
			begin
				prog.lock <= shift[35]; // [RULE_01]
				prog.data <= shift[34:3]; // [RULE_02]
				prog.addr <= shift[2:0]; // [RULE_03]
			end
		end
	end

	// config mirrors block 0 writes with the lock bit clear, password mirrors block 7; delivered value has the
	// request mode bit clear so the tag reads out at once [RULE_16]
	logic sw_cfg;
	logic sw_pwd;
	logic cfg_load;
	assign sw_cfg = clk_en && wr && addr == `REG_CFG;
	assign cfg_load = is_write && !shift[35] && shift[2:0] == `CFG_BLOCK;
	assign sw_pwd = clk_en && wr && addr == `REG_PWD;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			cfg <= `CFG_DEFAULT;
		else if (cfg_load)
			cfg <= shift[34:3];
		else if (sw_cfg)
			cfg <= wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			pwd <= `PWD_DEFAULT;
		else if (is_write && shift[2:0] == `PWD_BLOCK)
			pwd <= shift[34:3];
		else if (sw_pwd)
			pwd <= wdata;
	end

	// power-up sleep is latched at the first enabled cycle after reset;
	// cfg itself resets to the delivered value, so a config write re-arms
	// the latch as if the tag had re-entered the field, else request
	// mode could never take effect
	logic armed;
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			armed   <= 1'b0;
			awake   <= 1'b0;
			stopped <= 1'b0;
		end
		else if (clk_en)
		begin
			armed <= !(sw_cfg || cfg_load);
			if (!armed)
			begin
				awake   <= !cfg[`CFG_AOR_BIT]; // [RULE_12]
				stopped <= 1'b0;
			end
			else if (wake_ok)
			begin
				// internal reset: drop any stop, resume read mode
				awake   <= 1'b1; // [RULE_14]
				stopped <= 1'b0;
			end
			else if (is_stop)
				stopped <= 1'b1; // [RULE_15]
		end
	end

	// damping load only in read mode, never during a write frame
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			modulate_en <= 1'b0;
			write_mode  <= 1'b0;
		end
		else if (clk_en)
		begin
			modulate_en <= awake && !stopped
				&& rx_state == gap_write_pkg::RX_IDLE; // [RULE_17]
			write_mode  <= rx_state != gap_write_pkg::RX_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts and register read
	logic [`IRQ_W-1:0] irq_stat;
	logic [`IRQ_W-1:0] irq_mask;
	logic [`IRQ_W-1:0] irq_evt;

	assign irq_evt = {is_stop, wake_ok, bit_err && clk_en, is_write};

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			irq_stat <= '0;
		else if (clk_en)
		begin
			if (wr && addr == `REG_IRQ_STAT)
				irq_stat <= (irq_stat & ~wdata[`IRQ_W-1:0]) | irq_evt;
			else
				irq_stat <= irq_stat | irq_evt;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			irq_mask <= '0;
		else if (clk_en && wr && addr == `REG_IRQ_MASK)
			irq_mask <= wdata[`IRQ_W-1:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(irq_stat & irq_mask);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			rdata <= 32'h0;
		else if (clk_en)
		begin
			rdata <= 32'h0;
			if (rd)
			begin
				case (addr)
					`REG_CFG:       rdata <= cfg;
					`REG_PWD:       rdata <= pwd;
					`REG_STATUS:    rdata <= {26'h0, stopped, awake,
						nbits == `FRAME_BITS, gap_open, rx_state};
					`REG_IRQ_STAT:  rdata <= {28'h0, irq_stat};
					`REG_IRQ_MASK:  rdata <= {28'h0, irq_mask};
					`REG_LAST_DATA: rdata <= prog.data;
					`REG_LAST_ADDR: rdata <= {28'h0, prog.lock, prog.addr};
					default:        rdata <= 32'h0;
				endcase
			end
		end
	end

endmodule : gap_write_decoder

//--- pkg/gap_write_defines.svh
// constants for the gap write decoder: frame layout, count windows, offsets
// assumes inclusion by bare name from design and testbench files
`ifndef GAP_WRITE_DEFINES_SVH
`define GAP_WRITE_DEFINES_SVH
`define OP_WRITE        2'h2
`define OP_WAKE         2'h3
`define OP_STOP         2'h1
`define FRAME_BITS      6'h26
`define WAKE_BITS       6'h22
`define STOP_BITS       6'h02
`define ZERO_MIN        7'h10
`define ZERO_MAX        7'h20
`define ONE_MIN         7'h30
`define ONE_MAX         7'h40
`define CNT_SAT         7'h7f
`define CFG_BLOCK       3'h0
`define PWD_BLOCK       3'h7
`define CFG_AOR_BIT     0
`define CFG_DEFAULT     32'h0000_0000
`define PWD_DEFAULT     32'h0000_0000
`define REG_CFG         4'h0
`define REG_PWD         4'h1
`define REG_STATUS      4'h2
`define REG_IRQ_STAT    4'h3
`define REG_IRQ_MASK    4'h4
`define REG_LAST_DATA   4'h5
`define REG_LAST_ADDR   4'h6
`define IRQ_PROG        0
`define IRQ_ERR         1
`define IRQ_WAKE        2
`define IRQ_STOP        3
`define IRQ_W           4
`endif

//--- pkg/gap_write_pkg.sv
// types for the gap write decoder
// uses no macros from the defines header
package gap_write_pkg;
	typedef enum logic [1:0]
	{
		RX_IDLE  = 2'h0,
		RX_BITS  = 2'h1,
		RX_DONE  = 2'h3
	} rx_state_t;

	typedef struct packed
	{
		logic        req;
		logic [2:0]  addr;
		logic        lock;
		logic [31:0] data;
	} prog_req_t;
endpackage : gap_write_pkg

//--- verification/gap_write_decoder_assertions.sv
// port checker for the gap write decoder
// assumes one sys_clk domain and rstn synchronous, active low
`timescale 1ns/10ps
module gap_write_decoder_assertions
(
	input wire logic                     sys_clk,
	input wire logic                     rstn,
	input wire logic                     field_gap,
	input wire logic                     rd,
	input wire logic [31:0]              rdata,
	input wire logic                     modulate_en,
	input wire logic                     write_mode,
	input wire gap_write_pkg::prog_req_t prog
);
	logic       gap_q;
	logic [4:0] gap_age;

	// age since the last gap edge; decisions may only follow a gap
	always_ff @(posedge sys_clk)
	begin
		gap_q <= field_gap;
		if (!rstn || (field_gap && !gap_q))
			gap_age <= 5'h0;
		else if (gap_age != 5'h1f)
			gap_age <= gap_age + 5'h1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	a_req_pulse: assert property (prog.req |=> !prog.req)
		else $error("program request longer than one cycle");
	a_req_near_gap: assert property (prog.req |-> gap_age < 5'h18)
		else $error("program request far from a gap");
	a_req_in_frame: assert property (prog.req |-> $past(write_mode))
		else $error("program request outside a frame");
	a_write_opens: assert property
		($rose(write_mode) |-> gap_age < 5'h18)
		else $error("write mode entered without a gap");
	a_write_leaves: assert property
		($fell(write_mode) |-> gap_age < 5'h18)
		else $error("write mode left without a gap");
	a_mod_moves: assert property
		($changed(modulate_en) |-> gap_age < 5'h18)
		else $error("modulation changed without a gap");
	a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
		else $error("read data outside its cycle");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rstn |=> !prog.req && !write_mode && !modulate_en)
		else $error("outputs active after reset");

	c_prog: cover property (prog.req);
	c_stop: cover property ($fell(modulate_en));
	c_wake: cover property ($rose(modulate_en) && gap_age > 5'h4);
endmodule : gap_write_decoder_assertions

bind gap_write_decoder gap_write_decoder_assertions u_chk
(
	.sys_clk     (sys_clk),
	.rstn        (rstn),
	.field_gap   (field_gap),
	.rd          (rd),
	.rdata       (rdata),
	.modulate_en (modulate_en),
	.write_mode  (write_mode),
	.prog        (prog)
);

//--- verification/field_reader_model.sv
// reader model: gapped field carrier toward the decoder
// assumes a 200 ns carrier and one frame at a time
`timescale 1ns/10ps
module field_reader_model
(
	output logic field_clk,
	output logic field_gap
);
	initial
	begin
		field_clk = 1'b0;
		field_gap = 1'b0;
	end

	// carrier stands still outside frames
	task automatic run(input int n);
		repeat (n)
		begin
			#100 field_clk = 1'b1;
			#100 field_clk = 1'b0;
		end
	endtask : run

	// two decay pulses precede detection and are counted
	task automatic gap();
		run(2);
		field_gap = 1'b1;
		#1000 field_gap = 1'b0; // long gap, short on-times
	endtask : gap

	// msb first; the bit at index bad gets an out of range count
	task automatic send(input logic [37:0] v, input int nb, input int bad);
		gap();
		for (int i = nb - 1; i >= 0; i--)
		begin
			run(i == bad ? 38 : (v[i] ? 52 : 20));
			gap();
		end
		run(78);
		gap();
	endtask : send
endmodule : field_reader_model

//--- verification/gap_write_decoder_tb_top.sv
// testbench: reader model on the link, register tasks on the bus
// assumes the defines header is on the include path
`timescale 1ns/10ps
`include "gap_write_defines.svh"
module gap_write_decoder_tb_top;
	logic                     sys_clk = 1'b0;
	logic                     rstn;
	logic                     clk_en;
	logic                     field_clk;
	logic                     field_gap;
	logic [3:0]               addr;
	logic [31:0]              wdata;
	logic                     wr;
	logic                     rd;
	logic [31:0]              rdata;
	logic                     irq;
	logic                     modulate_en;
	logic                     write_mode;
	gap_write_pkg::prog_req_t prog;
	gap_write_pkg::prog_req_t got;
	int                       n_req = 0;
	int                       mismatches = 0;
	int                       n_tests = 0;

	gap_write_decoder u_dut
	(
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.clk_en      (clk_en),
		.field_clk   (field_clk),
		.field_gap   (field_gap),
		.addr        (addr),
		.wdata       (wdata),
		.wr          (wr),
		.rd          (rd),
		.rdata       (rdata),
		.irq         (irq),
		.modulate_en (modulate_en),
		.write_mode  (write_mode),
		.prog        (prog)
	);
	field_reader_model u_reader
	(
		.field_clk (field_clk),
		.field_gap (field_gap)
	);

	always #12.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		if (prog.req === 1'b1)
		begin
			n_req++;
			got <= prog;
		end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1)
		begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 check(rdata === e, "register read");
	endtask : rd_chk

	task automatic frame(input logic [37:0] v, input int nb, input int bad,
		input string t);
		u_reader.send(v, nb, bad);
		repeat (20) @(posedge sys_clk);
		$display("test %s done", t);
	endtask : frame

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	// whole run is about 66k cycles; allow 100k
	initial
	begin
		#2500000;
		mismatches++;
		$display("unexpected at %0t: watchdog", $time);
		results();
	end

	initial
	begin
		logic [37:0] wf;
		wf = {2'b10, 1'b1, 32'h8001_2c04, 3'h5};
		rstn = 1'b0;
		clk_en = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(modulate_en === 1'b1, "not reading");
		frame(wf, 38, -1, "write");
		check(got === {1'b1, 3'h5, 1'b1, 32'h8001_2c04}, "payload");
		rd_chk(`REG_LAST_DATA, 32'h8001_2c04);
		rd_chk(`REG_LAST_ADDR, 32'hd);
		rd_chk(4'hf, 32'h0);
		frame(wf >> 1, 37, -1, "short");
		check(n_req == 1, "short frame stored");
		frame({2'b00, wf[35:0]}, 38, -1, "opcode");
		check(n_req == 1, "bad opcode stored");
		frame(wf, 38, 30, "bad count");
		check(n_req == 1 && write_mode === 1'b0, "error frame");
		check(irq === 1'b0, "masked irq");
		wr_reg(`REG_IRQ_MASK, 32'h2);
		repeat (3) @(posedge sys_clk);
		check(irq === 1'b1, "error irq");
		wr_reg(`REG_IRQ_STAT, 32'h2);
		repeat (3) @(posedge sys_clk);
		check(irq === 1'b0, "irq clear");
		// a write while the enable is low must not land
		clk_en <= 1'b0;
		wr_reg(`REG_IRQ_MASK, 32'h0);
		clk_en <= 1'b1;
		rd_chk(`REG_IRQ_MASK, 32'h2);
		$display("test freeze done");
		frame({36'h0, 2'b01}, 2, -1, "stop");
		check(modulate_en === 1'b0, "still modulating");
		wr_reg(`REG_PWD, 32'h0000_0c05);
		wr_reg(`REG_CFG, 32'h1);
		rd_chk(`REG_STATUS, 32'h4);
		frame({4'h0, 2'b11, 32'h0000_0c04}, 34, -1, "wrong wake");
		check(modulate_en === 1'b0, "woke on bad password");
		frame({4'h0, 2'b11, 32'h0000_0c05}, 34, -1, "wake");
		check(modulate_en === 1'b1, "no wake");
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(modulate_en === 1'b1, "asleep after reset");
		rd_chk(`REG_CFG, 32'h0);
		$display("test reset done");
		results();
	end
endmodule : gap_write_decoder_tb_top
